// ### octal_uart_pkg.sv
package octal_uart_pkg;
	// Host address layout: top bit picks the global bank, then channel, then register
	localparam int          ADDR_W           = 8;
	localparam int          GLOBAL_BIT       = 7;
	localparam int          CHAN_LSB         = 4;
	// Channel register offsets
	localparam logic [3:0]  OFS_HOLDING      = 4'h0;
	localparam logic [3:0]  OFS_IEN          = 4'h1;
	localparam logic [3:0]  OFS_ISTAT        = 4'h2;
	localparam logic [3:0]  OFS_LINE_CTRL    = 4'h3;
	localparam logic [3:0]  OFS_MODEM_CTRL   = 4'h4;
	localparam logic [3:0]  OFS_LINE_STAT    = 4'h5;
	localparam logic [3:0]  OFS_MODEM_STAT   = 4'h6;
	localparam logic [3:0]  OFS_SCRATCH      = 4'h7;
	localparam logic [3:0]  OFS_FEATURE      = 4'h8;
	localparam logic [3:0]  OFS_ENHANCED     = 4'h9;
	localparam logic [3:0]  OFS_TX_LEVEL     = 4'ha;
	localparam logic [3:0]  OFS_RX_LEVEL     = 4'hb;
	localparam logic [3:0]  OFS_FLOW_FLAGS   = 4'hc;
	localparam int          DIV_ACCESS_POS   = 7;
	localparam logic [7:0]  FRACTION_MASK    = 8'h0f;
	// Global register offsets inside the global bank
	localparam logic [3:0]  OFS_TIMER_CMD    = 4'h0;
	localparam logic [3:0]  OFS_TIMER_RSVD   = 4'h1;
	localparam logic [3:0]  OFS_TIMER_LSB    = 4'h2;
	localparam logic [3:0]  OFS_TIMER_MSB    = 4'h3;
	localparam logic [3:0]  OFS_SAMPLE_SEL   = 4'h4;
	localparam logic [3:0]  OFS_RSVD_A       = 4'h5;
	localparam logic [3:0]  OFS_SOFT_RESET   = 4'h6;
	localparam logic [3:0]  OFS_SLEEP_EN     = 4'h7;
	localparam logic [3:0]  OFS_DEV_ID       = 4'h8;
	localparam logic [3:0]  OFS_REVISION     = 4'h9;
	localparam logic [3:0]  OFS_OPTIONS      = 4'ha;
	// Timer commands
	localparam logic [3:0]  CMD_INT_ON       = 4'h1;
	localparam logic [3:0]  CMD_INT_OFF      = 4'h2;
	localparam logic [3:0]  CMD_ONE_SHOT     = 4'h3;
	localparam logic [3:0]  CMD_RETRIGGER    = 4'h4;
	localparam logic [3:0]  CMD_SRC_INT      = 4'h5;
	localparam logic [3:0]  CMD_SRC_EXT      = 4'h6;
	localparam logic [3:0]  CMD_START        = 4'h9;
	localparam logic [3:0]  CMD_STOP         = 4'ha;
	localparam logic [3:0]  CMD_RESET        = 4'hb;
	localparam logic [7:0]  TIMER_PENDING    = 8'h01;
	// Reset values
	localparam logic [7:0]  REG_RESET        = 8'h00;
	localparam logic [15:0] COUNT_RESET      = 16'h0000;
	localparam int          BROADCAST_POS    = 0;
	// Wake-up settle time
	localparam int          WAKE_CLOCKS      = 32;
	localparam logic [5:0]  WAKE_CYCLES      = 6'(WAKE_CLOCKS);
	// Last sampling phase index per bit (phases per bit minus one)
	localparam logic [3:0]  PHASES_16X       = 4'hf;
	localparam logic [3:0]  PHASES_8X        = 4'h7;
	typedef enum logic [1:0] {OSC_RUN, OSC_STOPPED, OSC_WAKING} osc_state_t;
endpackage : octal_uart_pkg

// ### octal_uart_global_control.sv
`timescale 1ns/1ns
// Contract
// - One-shot timer raises its time-out once, exactly N timer clocks after start.
// - Re-triggerable timer times out every N timer clocks until stopped.
// - Reading the timer command register clears a pending timer interrupt.
// - Timer command register reads one while interrupt pending, else zero.
// - Sampling select holds one bit per channel; zero 16X, one 8X.
// - 8X sampling doubles bit rate for the same divisor.
// - Writing one to a soft reset bit resets that channel; bit self-clears.
// - Soft reset restores that channel's registers only.
// - Sleep register holds one enable per channel, default off.
// - A sleep-enabled channel sleeps only with no interrupt pending.
// - With all eight channels asleep the oscillator stops.
// - A received byte or serial input change wakes the stopped device.
// - Channel is operational 32 crystal clocks after wake-up.
// - Wake-up raises a special interrupt reporting no pending source.
// - Read-only 8-bit identification register returns a fixed device code.
// - Read-only 8-bit revision register returns the silicon revision.
// - Global options bit 0 makes channel writes apply to all channels.
// - Four address lines decode sixteen channel registers, standard then enhanced.
// - Address 0 is receive/transmit holding, or divisor low with divisor access.
// - Address 6 modem status/turn delay; 10 and 11 FIFO levels/triggers.
// - Addresses 12 to 15 hold flow characters; 12 reads flags, rest reserved.
// - Timer commands select mode, start, stop and interrupt enable.
module octal_uart_global_control
	import octal_uart_pkg::*;
#(
	parameter int          CHANNELS    = 8,
	parameter logic [7:0]  DEVICE_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0]  REVISION    = 8'h07  // Arbitrary value
) (
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	input  wire logic [ADDR_W-1:0]     addr,
	input  wire logic                  rd_strobe,
	input  wire logic                  wr_strobe,
	input  wire logic [7:0]            wdata,
	input  wire logic                  timer_ext_tick,
	input  wire logic [CHANNELS*8-1:0] chan_rx_byte,
	input  wire logic [CHANNELS*4-1:0] chan_int_source,
	input  wire logic [CHANNELS*8-1:0] chan_line_status,
	input  wire logic [CHANNELS*8-1:0] chan_modem_status,
	input  wire logic [CHANNELS*8-1:0] chan_tx_level,
	input  wire logic [CHANNELS*8-1:0] chan_rx_level,
	input  wire logic [CHANNELS*8-1:0] chan_flow_flags,
	input  wire logic [CHANNELS-1:0]   chan_wake_event,
	output logic      [7:0]            rdata_q,
	output logic      [CHANNELS-1:0]   cfg_wr_q,
	output logic      [CHANNELS-1:0]   cfg_rd_q,
	output logic      [3:0]            cfg_addr_q,
	output logic      [7:0]            cfg_data_q,
	output logic      [CHANNELS-1:0]   chan_reset_q,
	output logic      [CHANNELS-1:0]   sample_8x_q,
	output logic      [CHANNELS-1:0]   bit_tick_q,
	output logic      [CHANNELS-1:0]   asleep_q,
	output logic                       osc_stop_q,
	output logic                       chan_ready_q,
	output logic                       wake_irq_q,
	output logic                       timer_irq_q
);

	// Address split
	logic            glob_sel;
	logic [2:0]      chan_sel;
	logic [3:0]      reg_ofs;
	logic            gwr;
	logic            grd;
	assign glob_sel = addr[GLOBAL_BIT];
	assign chan_sel = addr[CHAN_LSB+2:CHAN_LSB];
	assign reg_ofs  = addr[3:0];
	assign gwr      = wr_strobe & glob_sel;
	assign grd      = rd_strobe & glob_sel;

	// Global registers
	logic [7:0]      options_q;
	logic [7:0]      sleep_en_q;
	logic [15:0]     count_n_q;

	// Per-channel stored configuration
	logic [7:0]      line_ctrl_q [CHANNELS];
	logic [7:0]      div_low_q   [CHANNELS];
	logic [7:0]      div_high_q  [CHANNELS];
	logic [7:0]      div_frac_q  [CHANNELS];
	logic [7:0]      ien_q       [CHANNELS];
	logic [7:0]      modem_ctl_q [CHANNELS];
	logic [7:0]      scratch_q   [CHANNELS];
	logic [7:0]      feature_q   [CHANNELS];
	logic [7:0]      enhanced_q  [CHANNELS];
	logic [CHANNELS-1:0] chan_wr;
	logic [CHANNELS-1:0] chan_rd;

	// Options, sleep enables, timer count, sampling select
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			options_q   <= REG_RESET;
			sleep_en_q  <= REG_RESET;
			count_n_q   <= COUNT_RESET;
			sample_8x_q <= '0;
		end else if (gwr) begin
			if (reg_ofs == OFS_OPTIONS)
				options_q <= {7'h00, wdata[BROADCAST_POS]};
			else if (reg_ofs == OFS_SLEEP_EN)
				sleep_en_q <= wdata;
			else if (reg_ofs == OFS_TIMER_LSB)
				count_n_q[7:0] <= wdata;
			else if (reg_ofs == OFS_TIMER_MSB)
				count_n_q[15:8] <= wdata;
			else if (reg_ofs == OFS_SAMPLE_SEL)
				sample_8x_q <= wdata[CHANNELS-1:0];
		end
	end

	// Soft reset pulses last one cycle; the register is not in the read mux, so it always reads back zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			chan_reset_q <= '0;
		else if (gwr && reg_ofs == OFS_SOFT_RESET)
			chan_reset_q <= wdata[CHANNELS-1:0];
		else
			chan_reset_q <= '0;
	end

	// Per-channel register decode, write side effects, baud ticks
	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
			logic        dacc;
			logic [15:0] div_full;
			logic [15:0] smp_cnt_q;
			logic [3:0]  phase_q;
			logic [3:0]  last_phase;
			assign dacc = line_ctrl_q[gi][DIV_ACCESS_POS];
			// Broadcast steers one write to every channel
			assign chan_wr[gi] = wr_strobe & ~glob_sel &
				(options_q[BROADCAST_POS] | (chan_sel == 3'(gi)));
			assign chan_rd[gi] = rd_strobe & ~glob_sel & (chan_sel == 3'(gi));

			// Stored registers; soft reset beats a same-cycle write
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					line_ctrl_q[gi] <= REG_RESET;
					div_low_q[gi]   <= REG_RESET;
					div_high_q[gi]  <= REG_RESET;
					div_frac_q[gi]  <= REG_RESET;
					ien_q[gi]       <= REG_RESET;
					modem_ctl_q[gi] <= REG_RESET;
					scratch_q[gi]   <= REG_RESET;
					feature_q[gi]   <= REG_RESET;
					enhanced_q[gi]  <= REG_RESET;
				end else if (chan_reset_q[gi]) begin
					line_ctrl_q[gi] <= REG_RESET;
					div_low_q[gi]   <= REG_RESET;
					div_high_q[gi]  <= REG_RESET;
					div_frac_q[gi]  <= REG_RESET;
					ien_q[gi]       <= REG_RESET;
					modem_ctl_q[gi] <= REG_RESET;
					scratch_q[gi]   <= REG_RESET;
					feature_q[gi]   <= REG_RESET;
					enhanced_q[gi]  <= REG_RESET;
				end else if (chan_wr[gi]) begin
					if (reg_ofs == OFS_HOLDING && dacc)
						div_low_q[gi] <= wdata;
					else if (reg_ofs == OFS_IEN && dacc)
						div_high_q[gi] <= wdata;
					else if (reg_ofs == OFS_IEN)
						ien_q[gi] <= wdata;
					else if (reg_ofs == OFS_ISTAT && dacc)
						div_frac_q[gi] <= wdata & FRACTION_MASK;
					else if (reg_ofs == OFS_LINE_CTRL)
						line_ctrl_q[gi] <= wdata;
					else if (reg_ofs == OFS_MODEM_CTRL)
						modem_ctl_q[gi] <= wdata;
					else if (reg_ofs == OFS_SCRATCH)
						scratch_q[gi] <= wdata;
					else if (reg_ofs == OFS_FEATURE)
						feature_q[gi] <= wdata;
					else if (reg_ofs == OFS_ENHANCED)
						enhanced_q[gi] <= wdata;
				end
			end

			// Bit tick: sample clock from the divisor, then 16 or 8 samples per bit
			assign div_full   = {div_high_q[gi], div_low_q[gi]};
			assign last_phase = sample_8x_q[gi] ? PHASES_8X : PHASES_16X;
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					smp_cnt_q      <= COUNT_RESET;
					phase_q        <= '0;
					bit_tick_q[gi] <= 1'b0;
				end else if (chan_reset_q[gi] || div_full == COUNT_RESET) begin
					smp_cnt_q      <= COUNT_RESET;
					phase_q        <= '0;
					bit_tick_q[gi] <= 1'b0;
				end else if (smp_cnt_q >= div_full - 16'h0001) begin
					smp_cnt_q      <= COUNT_RESET;
					phase_q        <= (phase_q >= last_phase) ? 4'h0 : phase_q + 4'h1;
					bit_tick_q[gi] <= (phase_q >= last_phase);
				end else begin
					smp_cnt_q      <= smp_cnt_q + 16'h0001;
					bit_tick_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Channel strobes forwarded to the channel cores, one cycle long
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cfg_wr_q   <= '0;
			cfg_rd_q   <= '0;
			cfg_addr_q <= '0;
			cfg_data_q <= REG_RESET;
		end else begin
			cfg_wr_q <= chan_wr & ~chan_reset_q;
			cfg_rd_q <= chan_rd;
			if (wr_strobe || rd_strobe) begin
				cfg_addr_q <= reg_ofs;
				cfg_data_q <= wdata;
			end
		end
	end

	// Timer state
	logic            tmr_run_q;
	logic            tmr_retrig_q;
	logic            tmr_ext_q;
	logic            tmr_int_en_q;
	logic [15:0]     tmr_cnt_q;
	logic            tmr_tick;
	logic            tmr_timeout;
	logic            cmd_wr;
	logic            cmd_rd;
	assign cmd_wr      = gwr && reg_ofs == OFS_TIMER_CMD;
	assign cmd_rd      = grd && reg_ofs == OFS_TIMER_CMD;
	assign tmr_tick    = tmr_ext_q ? timer_ext_tick : 1'b1;
	assign tmr_timeout = tmr_run_q && tmr_tick && tmr_cnt_q == 16'h0001;

	// Timer command decode and down-counter; reserved codes fall through untouched
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tmr_run_q    <= 1'b0;
			tmr_retrig_q <= 1'b0;
			tmr_ext_q    <= 1'b0;
			tmr_int_en_q <= 1'b0;
			tmr_cnt_q    <= COUNT_RESET;
		end else if (cmd_wr) begin
			case (wdata[3:0])
				CMD_INT_ON:    tmr_int_en_q <= 1'b1;
				CMD_INT_OFF:   tmr_int_en_q <= 1'b0;
				CMD_ONE_SHOT:  tmr_retrig_q <= 1'b0;
				CMD_RETRIGGER: tmr_retrig_q <= 1'b1;
				CMD_SRC_INT:   tmr_ext_q    <= 1'b0;
				CMD_SRC_EXT:   tmr_ext_q    <= 1'b1;
				CMD_START: begin
					tmr_run_q <= 1'b1;
					tmr_cnt_q <= count_n_q;
				end
				CMD_STOP:      tmr_run_q    <= 1'b0;
				CMD_RESET: begin
					tmr_run_q    <= 1'b0;
					tmr_retrig_q <= 1'b0;
					tmr_cnt_q    <= COUNT_RESET;
				end
				default:       tmr_run_q    <= tmr_run_q;
			endcase
		end else if (tmr_timeout) begin
			tmr_cnt_q <= count_n_q;
			tmr_run_q <= tmr_retrig_q;
		end else if (tmr_run_q && tmr_tick) begin
			tmr_cnt_q <= tmr_cnt_q - 16'h0001;
		end
	end

	// Pending flag: a time-out in the clearing read's cycle still lands
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			timer_irq_q <= 1'b0;
		else if (tmr_timeout && tmr_int_en_q)
			timer_irq_q <= 1'b1;
		else if (cmd_rd)
			timer_irq_q <= 1'b0;
	end

	// Sleep and oscillator control
	osc_state_t      osc_q;
	logic [5:0]      wake_cnt_q;
	logic [CHANNELS-1:0] int_busy;
	logic            wake_seen;
	logic            istat_rd;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_busy
			assign int_busy[gi] = chan_int_source[gi*4 +: 4] != 4'h0;
		end
	endgenerate
	assign wake_seen = |chan_wake_event;
	assign istat_rd  = |chan_rd && reg_ofs == OFS_ISTAT && !line_ctrl_q[chan_sel][DIV_ACCESS_POS];

	// Channels doze only while enabled, idle and the clock is settled
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			asleep_q <= '0;
		else if (osc_q == OSC_RUN)
			asleep_q <= sleep_en_q[CHANNELS-1:0] & ~int_busy & ~chan_wake_event;
		else if (osc_q == OSC_WAKING)
			asleep_q <= '0;
		// Clearing an enable while stopped takes that channel out of sleep at once
		else
			asleep_q <= asleep_q & sleep_en_q[CHANNELS-1:0];
	end

	// Oscillator stop, wake and settle sequence
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			osc_q        <= OSC_RUN;
			wake_cnt_q   <= '0;
			osc_stop_q   <= 1'b0;
			chan_ready_q <= 1'b1;
		end else begin
			case (osc_q)
				OSC_RUN: begin
					if (&asleep_q) begin
						osc_q        <= OSC_STOPPED;
						osc_stop_q   <= 1'b1;
						chan_ready_q <= 1'b0;
					end
				end
				OSC_STOPPED: begin
					if (wake_seen) begin
						osc_q      <= OSC_WAKING;
						osc_stop_q <= 1'b0;
						wake_cnt_q <= '0;
					end
				end
				OSC_WAKING: begin
					if (wake_cnt_q == WAKE_CYCLES - 6'd1) begin
						osc_q        <= OSC_RUN;
						chan_ready_q <= 1'b1;
					end else begin
						wake_cnt_q <= wake_cnt_q + 6'd1;
					end
				end
				default: osc_q <= OSC_RUN;
			endcase
		end
	end

	// Wake indicator holds until the host reads an interrupt status register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			wake_irq_q <= 1'b0;
		else if (osc_q == OSC_STOPPED && wake_seen)
			wake_irq_q <= 1'b1;
		else if (istat_rd)
			wake_irq_q <= 1'b0;
	end

	// Read mux; the wake indicator forces a no-source interrupt code
	logic [7:0]      rd_val;
	logic [2:0]      c;
	always_comb begin
		c      = chan_sel;
		rd_val = REG_RESET;
		if (glob_sel) begin
			if (reg_ofs == OFS_TIMER_CMD)
				rd_val = timer_irq_q ? TIMER_PENDING : REG_RESET;
			else if (reg_ofs == OFS_TIMER_LSB)
				rd_val = count_n_q[7:0];
			else if (reg_ofs == OFS_TIMER_MSB)
				rd_val = count_n_q[15:8];
			else if (reg_ofs == OFS_SAMPLE_SEL)
				rd_val = sample_8x_q;
			else if (reg_ofs == OFS_SLEEP_EN)
				rd_val = sleep_en_q;
			else if (reg_ofs == OFS_DEV_ID)
				rd_val = DEVICE_CODE;
			else if (reg_ofs == OFS_REVISION)
				rd_val = REVISION;
			else if (reg_ofs == OFS_OPTIONS)
				rd_val = options_q;
		end else if (reg_ofs == OFS_HOLDING) begin
			rd_val = line_ctrl_q[c][DIV_ACCESS_POS] ? div_low_q[c] : chan_rx_byte[c*8 +: 8];
		end else if (reg_ofs == OFS_IEN) begin
			rd_val = line_ctrl_q[c][DIV_ACCESS_POS] ? div_high_q[c] : ien_q[c];
		end else if (reg_ofs == OFS_ISTAT) begin
			if (line_ctrl_q[c][DIV_ACCESS_POS])
				rd_val = div_frac_q[c];
			else if (wake_irq_q)
				rd_val = 8'h01;
			else
				rd_val = {4'h0, chan_int_source[c*4 +: 4]};
		end else if (reg_ofs == OFS_LINE_CTRL)
			rd_val = line_ctrl_q[c];
		else if (reg_ofs == OFS_MODEM_CTRL)
			rd_val = modem_ctl_q[c];
		else if (reg_ofs == OFS_LINE_STAT)
			rd_val = chan_line_status[c*8 +: 8];
		else if (reg_ofs == OFS_MODEM_STAT)
			rd_val = chan_modem_status[c*8 +: 8];
		else if (reg_ofs == OFS_SCRATCH)
			rd_val = scratch_q[c];
		else if (reg_ofs == OFS_FEATURE)
			rd_val = feature_q[c];
		else if (reg_ofs == OFS_ENHANCED)
			rd_val = enhanced_q[c];
		else if (reg_ofs == OFS_TX_LEVEL)
			rd_val = chan_tx_level[c*8 +: 8];
		else if (reg_ofs == OFS_RX_LEVEL)
			rd_val = chan_rx_level[c*8 +: 8];
		else if (reg_ofs == OFS_FLOW_FLAGS)
			rd_val = chan_flow_flags[c*8 +: 8];
	end

	// Read data is captured on the strobe and held until the next read
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			rdata_q <= REG_RESET;
		else if (rd_strobe)
			rdata_q <= rd_val;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	// Helper: cycles since the last start command
	logic [16:0]     since_start_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			since_start_q <= '0;
		else if (cmd_wr && wdata[3:0] == CMD_START)
			since_start_q <= 17'd1;
		else if (since_start_q != '0 && ~&since_start_q)
			since_start_q <= since_start_q + 17'd1;
	end

	// Helper: cycles since a wake event was taken, zero otherwise
	logic [5:0]      settle_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			settle_q <= '0;
		else if (osc_q == OSC_STOPPED && wake_seen)
			settle_q <= 6'd1;
		else if (settle_q != 6'd0 && settle_q <= WAKE_CYCLES)
			settle_q <= settle_q + 6'd1;
		else
			settle_q <= '0;
	end

	one_shot_time_a: assert property (
		tmr_timeout && !tmr_ext_q && !tmr_retrig_q && !cmd_wr |-> since_start_q[15:0] == count_n_q
	) else $error("one-shot timeout not N clocks after start");
	retrig_period_a: assert property (
		(tmr_timeout && tmr_retrig_q && !tmr_ext_q && count_n_q == 16'h0005)
			##1 !cmd_wr [*4] |=> tmr_timeout
	) else $error("re-triggerable period wrong");
	cmd_read_clear_a: assert property (
		cmd_rd && !tmr_timeout |=> !timer_irq_q
	) else $error("timer pending not cleared by read");
	cmd_read_value_a: assert property (
		rd_strobe && glob_sel && reg_ofs == OFS_TIMER_CMD |=> rdata_q == {7'h00, $past(timer_irq_q)}
	) else $error("timer command readback wrong");
	soft_reset_pulse_a: assert property (
		chan_reset_q[0] |=> !chan_reset_q[0] || $past(gwr)
	) else $error("soft reset bit not self-clearing");
	reset_clears_a: assert property (
		chan_reset_q[0] |=> scratch_q[0] == REG_RESET && line_ctrl_q[0] == REG_RESET
	) else $error("soft reset left channel registers");
	sleep_idle_a: assert property (
		asleep_q[0] |-> $past(sleep_en_q[0]) && !$past(int_busy[0])
	) else $error("channel slept with interrupt pending");
	osc_stop_a: assert property (
		$rose(osc_stop_q) |-> $past(&asleep_q)
	) else $error("oscillator stopped without all channels asleep");
	wake_settle_a: assert property (
		settle_q != 6'd0 && settle_q <= WAKE_CYCLES |-> !chan_ready_q
	) else $error("channel ready before wake settle time");
	wake_ready_a: assert property (
		settle_q == WAKE_CYCLES + 6'd1 |-> chan_ready_q
	) else $error("channel not ready after wake settle time");
	wake_flag_a: assert property (
		osc_q == OSC_STOPPED && wake_seen |=> wake_irq_q
	) else $error("wake indicator not raised");
	broadcast_a: assert property (
		wr_strobe && !glob_sel && options_q[0] && !(|chan_reset_q) |=> &cfg_wr_q
	) else $error("broadcast write not applied to all channels");

endmodule : octal_uart_global_control

// ### host_model.sv
`timescale 1ns/1ns
// Host side of the register bus: one strobe per access, driven 1 ns after an edge
module host_model (
	input  wire logic       clock,
	output logic      [7:0] addr,
	output logic            rd_strobe,
	output logic            wr_strobe,
	output logic      [7:0] wdata
);
	initial begin
		addr = 8'h00;
		rd_strobe = 1'b0;
		wr_strobe = 1'b0;
		wdata = 8'h00;
	end
	// A free edge first, so a strobe never drops and rises in one time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 addr = a;
		wdata = d;
		wr_strobe = 1'b1;
		@(posedge clock);
		#1 wr_strobe = 1'b0;
		wdata = ~d; // Stale data is not left looking valid
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		#1 addr = a;
		rd_strobe = 1'b1;
		@(posedge clock);
		#1 rd_strobe = 1'b0;
	endtask : rd
endmodule : host_model

// ### octal_uart_global_control_tb.sv
`timescale 1ns/1ns
module octal_uart_global_control_tb;
	import octal_uart_pkg::*;
	localparam logic [7:0] ID_CODE = 8'h3c; // Arbitrary value
	localparam logic [7:0] REV     = 8'h05; // Arbitrary value
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  addr, wdata, rdata_q, cfg_wr_q, cfg_data_q, chan_reset_q, sample_8x_q, asleep_q;
	logic        rd_strobe, wr_strobe, osc_stop_q, chan_ready_q, wake_irq_q, timer_irq_q;
	logic [3:0]  cfg_addr_q;
	logic [63:0] rx_byte = 64'h0, lvl = 64'h0, flags = 64'h0, modem = 64'h0;
	logic [31:0] int_src = 32'h0;
	logic [7:0]  wake = 8'h00, bit_tick_q, cfg_rd_q;
	logic        ext_tick = 1'b0;
	int          num_errors = 0;
	int          n_compared = 0;
	int          n;
	always #5 clock = ~clock;
	host_model host_model_i (.clock(clock), .addr(addr), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wdata(wdata));
	octal_uart_global_control #(.DEVICE_CODE(ID_CODE), .REVISION(REV)) octal_uart_global_control_i (
		.clock(clock), .reset_n(reset_n), .addr(addr), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
		.wdata(wdata), .timer_ext_tick(ext_tick), .chan_rx_byte(rx_byte), .chan_int_source(int_src),
		.chan_line_status(~modem), .chan_modem_status(modem), .chan_tx_level(lvl), .chan_rx_level(~lvl),
		.chan_flow_flags(flags), .chan_wake_event(wake), .rdata_q(rdata_q), .cfg_wr_q(cfg_wr_q),
		.cfg_rd_q(cfg_rd_q), .cfg_addr_q(cfg_addr_q), .cfg_data_q(cfg_data_q), .chan_reset_q(chan_reset_q),
		.sample_8x_q(sample_8x_q), .bit_tick_q(bit_tick_q), .asleep_q(asleep_q), .osc_stop_q(osc_stop_q),
		.chan_ready_q(chan_ready_q), .wake_irq_q(wake_irq_q), .timer_irq_q(timer_irq_q));
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		host_model_i.rd(a);
		chk("rdata", rdata_q, exp);
	endtask : rdchk
	// Counts edges until the timer flag (0), ready (1) or channel 1 bit tick (2) is high; a hang ends the run
	task automatic wait_hi(input int sel);
		n = 0;
		do begin
			@(posedge clock);
			#1 n++;
			if (n > 300) begin
				num_errors++;
				results();
			end
		end while (((sel == 0) ? timer_irq_q : (sel == 1) ? chan_ready_q : bit_tick_q[1]) !== 1'b1);
	endtask : wait_hi
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results
	initial begin
		repeat (12) @(posedge clock);
		#1 reset_n = 1'b1;
		chk("ready", chan_ready_q, 1'b1);
		rdchk(8'h80, 8'h00);
		rdchk(8'h84, 8'h00);
		rdchk(8'h87, 8'h00);
		rdchk(8'h8a, 8'h00);
		rdchk(8'h88, ID_CODE);
		rdchk(8'h89, REV);
		host_model_i.wr(8'h85, 8'hff);
		rdchk(8'h85, 8'h00);
		host_model_i.wr(8'h84, 8'ha5);
		chk("sample_8x", sample_8x_q, 8'ha5);
		rdchk(8'h84, 8'ha5);
		$display("test registers done");
		// Count of five; the flag rises N edges after the start edge
		host_model_i.wr(8'h82, 8'h05);
		host_model_i.wr(8'h83, 8'h00);
		host_model_i.wr(8'h80, {4'h0, CMD_INT_ON});
		host_model_i.wr(8'h80, {4'h0, CMD_ONE_SHOT});
		host_model_i.wr(8'h80, {4'h0, CMD_START});
		wait_hi(0);
		chk("one_shot", 16'(n), 16'd5);
		rdchk(8'h80, TIMER_PENDING);
		chk("timer_irq", timer_irq_q, 1'b0);
		repeat (12) @(posedge clock);
		#1 chk("once", timer_irq_q, 1'b0);
		rdchk(8'h80, 8'h00);
		host_model_i.wr(8'h80, {4'h0, CMD_RETRIGGER});
		host_model_i.wr(8'h80, {4'h0, CMD_START});
		wait_hi(0);
		rdchk(8'h80, TIMER_PENDING);
		wait_hi(0);
		chk("period", 16'(n), 16'd3);
		host_model_i.wr(8'h80, {4'h0, CMD_STOP});
		rdchk(8'h80, TIMER_PENDING);
		repeat (12) @(posedge clock);
		#1 chk("stopped", timer_irq_q, 1'b0);
		// External source: the count holds while the tick input stays low
		host_model_i.wr(8'h80, {4'h0, CMD_ONE_SHOT});
		host_model_i.wr(8'h80, {4'h0, CMD_SRC_EXT});
		host_model_i.wr(8'h80, {4'h0, CMD_START});
		repeat (12) @(posedge clock);
		#1 chk("ext_hold", timer_irq_q, 1'b0);
		ext_tick = 1'b1;
		wait_hi(0);
		chk("ext_count", 16'(n), 16'd5);
		ext_tick = 1'b0;
		rdchk(8'h80, TIMER_PENDING);
		host_model_i.wr(8'h80, {4'h0, CMD_SRC_INT});
		host_model_i.wr(8'h80, {4'h0, CMD_RETRIGGER});
		host_model_i.wr(8'h80, {4'h0, CMD_START});
		host_model_i.wr(8'h80, {4'h0, CMD_RESET});
		repeat (12) @(posedge clock);
		#1 chk("timer_reset", timer_irq_q, 1'b0);
		$display("test timer done");
		host_model_i.wr(8'h07, 8'h5c);
		host_model_i.wr(8'h17, 8'h33);
		host_model_i.wr(8'h86, 8'h81);
		chk("chan_reset", chan_reset_q, 8'h81);
		rdchk(8'h86, 8'h00);
		chk("chan_reset", chan_reset_q, 8'h00);
		rdchk(8'h07, 8'h00);
		rdchk(8'h17, 8'h33);
		host_model_i.wr(8'h8a, 8'h01);
		host_model_i.wr(8'h23, 8'h1b);
		chk("bcast", cfg_wr_q, 8'hff);
		chk("cfg_addr", cfg_addr_q, OFS_LINE_CTRL);
		chk("cfg_data", cfg_data_q, 8'h1b);
		host_model_i.wr(8'h8a, 8'h00);
		host_model_i.wr(8'h23, 8'h03);
		chk("single", cfg_wr_q, 8'h04);
		rx_byte[15:8] = 8'h3c;
		modem[15:8] = 8'h96;
		lvl[15:8] = 8'h21;
		flags[15:8] = 8'h0a;
		rdchk(8'h10, 8'h3c);
		rdchk(8'h16, 8'h96);
		rdchk(8'h1a, 8'h21);
		rdchk(8'h1b, 8'hde);
		rdchk(8'h1c, 8'h0a);
		rdchk(8'h1d, 8'h00);
		rdchk(8'h15, 8'h69);
		chk("cfg_rd", cfg_rd_q, 8'h02);
		// Divisor bank on channel 1, then a divisor of two for the bit tick
		host_model_i.wr(8'h13, 8'h80);
		host_model_i.wr(8'h10, 8'h02);
		host_model_i.wr(8'h11, 8'h34);
		host_model_i.wr(8'h12, 8'hff);
		rdchk(8'h10, 8'h02);
		rdchk(8'h11, 8'h34);
		rdchk(8'h12, 8'h0f);
		host_model_i.wr(8'h11, 8'h00);
		host_model_i.wr(8'h13, 8'h03);
		wait_hi(2);
		wait_hi(2);
		chk("bit_16x", 16'(n), 16'd32);
		host_model_i.wr(8'h84, 8'h02);
		wait_hi(2);
		wait_hi(2);
		chk("bit_8x", 16'(n), 16'd16);
		$display("test decode done");
		// Channel 0 busy with an interrupt keeps the oscillator alive
		int_src[3:0] = 4'h2;
		host_model_i.wr(8'h87, 8'hff);
		repeat (3) @(posedge clock);
		#1 chk("asleep", asleep_q, 8'hfe);
		chk("osc", osc_stop_q, 1'b0);
		int_src[3:0] = 4'h0;
		repeat (3) @(posedge clock);
		#1 chk("osc", osc_stop_q, 1'b1);
		wake[3] = 1'b1;
		@(posedge clock);
		#1 wake[3] = 1'b0;
		chk("osc", osc_stop_q, 1'b0);
		chk("wake_irq", wake_irq_q, 1'b1);
		wait_hi(1);
		chk("wake_time", 16'(n), 16'd32);
		host_model_i.wr(8'h87, 8'h00);
		rdchk(8'h02, 8'h01);
		chk("wake_irq", wake_irq_q, 1'b0);
		$display("test sleep done");
		results();
	end
endmodule : octal_uart_global_control_tb
